// [core/apr_pkg.sv]
/*
  constants for the port control and status register bank: offsets, fields, resets.
  assumes an 8-bit host port with 8-bit addresses; bits 7:5 pick the port.
*/
package apr_pkg;
  localparam int APR_PORTS = 8;
  localparam logic [4:0] APR_OFF_TX_LINE_CTRL = 5'h07;
  localparam logic [4:0] APR_OFF_TX_CELL_CTRL = 5'h06;
  localparam logic [4:0] APR_OFF_LATCH = 5'h01;
  localparam logic [4:0] APR_OFF_CNT_HI = 5'h02;
  localparam logic [4:0] APR_OFF_CNT_LO = 5'h03;
  localparam logic [7:0] APR_ADDR_FILLER = 8'h04;
  localparam logic [7:0] APR_ADDR_HEC_PAT = 8'h05;
  localparam logic [7:0] APR_ADDR_SUMMARY = 8'h08;
  localparam logic [7:0] APR_ADDR_RX_CFG = 8'h10;
  localparam logic [4:0] APR_OFF_STATUS = 5'h18;
  localparam logic [4:0] APR_OFF_RX_CELL = 5'h19;
  localparam logic [4:0] APR_OFF_RX_IRQ = 5'h1a;
  localparam logic [7:0] APR_RST_FILLER = 8'h6a;
  localparam logic [7:0] APR_RST_HEC_PAT = 8'h00;
  localparam logic [7:0] APR_RST_RX_CFG = 8'h10;
  localparam logic [7:0] APR_RST_TX_CELL = 8'h05;
  localparam logic [7:0] APR_COSET = 8'h55;
  localparam logic [2:0] APR_CLK_DIV = 3'h7;
  localparam logic [2:0] APR_FIFO_CAP = 3'h4;
  // status bits
  localparam int APR_ST_OVR = 0;
  localparam int APR_ST_DCHG = 1;
  localparam int APR_ST_LOST = 2;
  localparam int APR_ST_MODE = 3;
  localparam int APR_ST_PAR = 6;
  localparam int APR_ST_EXT = 7;
  // control bits
  localparam int APR_TX_HEC_INS = 0;
  localparam int APR_TX_HEC_ERR = 1;
  localparam int APR_TX_PAR_MASK = 6;
  localparam int APR_TX_CLK_SEL = 6;
  localparam int APR_RX_COSET = 0;
  localparam int APR_RX_CORR = 1;
  localparam int APR_RX_DESCR = 2;
  localparam int APR_RX_PASS = 3;
  localparam int APR_RX_IDLE = 4;
  localparam int APR_RX_UNAS = 5;
  localparam int APR_RX_LOOP = 0;
  localparam int APR_RX_OVR_MASK = 3;
  localparam int APR_RX_DEL_MASK = 4;
  localparam int APR_RX_EXT_MASK = 5;
  typedef enum logic [1:0] {
    APR_HUNT = 2'b00,
    APR_PRESYNC = 2'b01,
    APR_SYNC = 2'b10
  } apr_delin_t;
endpackage

// [core/apr_cnt_if.sv]
/*
  carrier between the register bank and its per-port cell counter.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface apr_cnt_if;
  logic [7:0] cell_sent;
  logic [7:0] clear;
  logic [127:0] count;
  modport bank (output cell_sent, output clear, input count);
  modport counter (input cell_sent, input clear, output count);
endinterface

// [core/apr_cell_counter.sv]
/*
  eight 16-bit transmit cell counters, one per port, cleared on latch.
  assumes clear and cell events arrive on ref_clk.
*/
`timescale 1ns/1ps
module apr_cell_counter
  import apr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  apr_cnt_if.counter cnt
);
  logic [15:0] count [APR_PORTS];

  // clear wins; a cell sent in the latch cycle is in neither the copy nor the new count
  always_ff @(posedge ref_clk or negedge nrst) begin
    for (int i = 0; i < APR_PORTS; i++) begin
      if (!nrst) begin
        count[i] <= 16'h0000;
      end else if (cnt.clear[i]) begin
        count[i] <= 16'h0000;
      end else if (cnt.cell_sent[i]) begin
        count[i] <= count[i] + 16'h0001;
      end
    end
  end

  // flatten for the bank
  always_comb begin
    cnt.count = '0;
    for (int i = 0; i < APR_PORTS; i++) begin
      cnt.count[i*16 +: 16] = count[i];
    end
  end
endmodule

// [core/apr_port_regs.sv]
/*
  control and status register bank of the eight-port cell-over-tdm phy.
  assumes host strobes are synchronous one-cycle pulses on ref_clk, and
  that the datapath reports events as one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module apr_port_regs
  import apr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic irq_n,
  input wire logic [7:0] tx_cell_sent,
  input wire logic [7:0] tx_parity_err,
  input wire logic [7:0] ext_status,
  input wire logic [7:0] rx_cell_stored,
  input wire logic [7:0] rx_cell_read,
  input wire logic [15:0] delin_state,
  input wire logic [7:0] rx_error_mode,
  input wire logic [7:0] framer_tx_clock,
  input wire logic [7:0] tx_hec_cell,
  input wire logic [7:0] rx_hec_byte,
  input wire logic [7:0] rx_hec_calc,
  input wire logic [31:0] rx_header,
  input wire logic rx_hec_single,
  input wire logic [2:0] rx_port,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] rx_line_data,
  input wire logic [7:0] rx_line_clock,
  output logic [7:0] tx_line_clock,
  output logic [23:0] tx_fifo_depth,
  output logic [7:0] filler_payload_byte,
  output logic [7:0] tx_bad_hec,
  output logic [7:0] rx_line_type,
  output logic [7:0] rx_poll_cfg,
  output logic [7:0] rx_null_port,
  output logic rx_hec_ok,
  output logic rx_correct,
  output logic rx_descramble,
  output logic rx_forward,
  output logic [7:0] rx_fifo_full,
  output logic [7:0] rx_sel_data,
  output logic [7:0] rx_sel_clock
);
  apr_cnt_if cnt ();
  logic [7:0] tx_line_ctrl [APR_PORTS];
  logic [7:0] tx_cell_ctrl [APR_PORTS];
  logic [7:0] rx_cell_control [APR_PORTS];
  logic [7:0] rx_line_irq_control [APR_PORTS];
  logic [7:0] evt [APR_PORTS];
  logic [2:0] fill [APR_PORTS];
  logic [4:0] hec_run [APR_PORTS];
  logic hec_bad_phase [APR_PORTS];
  logic [2:0] div_cnt;
  logic div_clk;
  logic [15:0] tx_cell_count;
  logic [7:0] filler;
  logic [7:0] hec_error_pattern;
  logic [7:0] rx_shared_config;
  logic [7:0] ext_s1, ext_s2, ext_s3;
  logic [7:0] ext_lvl;
  logic [7:0] lost_q;
  logic [7:0] summary;
  logic [2:0] port_sel;
  logic [4:0] off;
  logic wr_latch, rd_status;
  logic [7:0] next_rdata;
  logic [7:0] status_view;
  logic [7:0] ext_rise;
  logic [7:0] lost_now;
  logic [7:0] hec_chk;
  logic rx_hec_good;
  logic rx_sync;
  apr_delin_t rx_state;

  // address split: port in bits 7:5, register in 4:0
  assign port_sel = host_addr[7:5];
  assign off = host_addr[4:0];
  assign wr_latch = host_wr && off == APR_OFF_LATCH;
  assign rd_status = host_rd && off == APR_OFF_STATUS;

  apr_cell_counter u_counter (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cnt(cnt)
  );
  assign cnt.cell_sent = tx_cell_sent;
  assign cnt.clear = wr_latch ? (8'h01 << port_sel) : 8'h00;

  // live status view of a port
  function automatic logic [7:0] stat(input int p);
    stat = evt[p];
    stat[APR_ST_LOST] = lost_now[p];
    stat[APR_ST_MODE] = rx_error_mode[p];
    stat[5:4] = delin_state[p*2 +: 2];
  endfunction

  // buffer depth in cells for a depth code; the reserved code keeps four
  function automatic logic [2:0] depth_cells(input logic [1:0] code);
    depth_cells = code == 2'b11 ? APR_FIFO_CAP : APR_FIFO_CAP - {1'b0, code};
  endfunction

  // enabled flags of a port
  function automatic logic pend(input int p);
    pend = (evt[p][APR_ST_OVR] && rx_line_irq_control[p][APR_RX_OVR_MASK]) ||
           (evt[p][APR_ST_DCHG] && rx_line_irq_control[p][APR_RX_DEL_MASK]) ||
           (evt[p][APR_ST_PAR] && tx_cell_ctrl[p][APR_TX_PAR_MASK]) ||
           (evt[p][APR_ST_EXT] && rx_line_irq_control[p][APR_RX_EXT_MASK]);
  endfunction

  // loss of delineation: anything but sync
  always_comb begin
    for (int i = 0; i < APR_PORTS; i++) begin
      lost_now[i] = !delin_state[i*2+1];
    end
  end
  // a rise counts once stages two and three agree high over a settled low
  assign ext_rise = ext_s2 & ext_s3 & ~ext_lvl;
  assign status_view = stat(int'(port_sel));

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    unique case (off)
      APR_OFF_CNT_HI: next_rdata = tx_cell_count[15:8];
      APR_OFF_CNT_LO: next_rdata = tx_cell_count[7:0];
      APR_OFF_STATUS: next_rdata = status_view;
      APR_OFF_RX_CELL: next_rdata = rx_cell_control[port_sel];
      APR_OFF_RX_IRQ: next_rdata = rx_line_irq_control[port_sel];
      APR_OFF_TX_CELL_CTRL: next_rdata = tx_cell_ctrl[port_sel];
      APR_OFF_TX_LINE_CTRL: next_rdata = tx_line_ctrl[port_sel];
      default: begin
        if (host_addr == APR_ADDR_FILLER) next_rdata = filler;
        else if (host_addr == APR_ADDR_HEC_PAT) next_rdata = hec_error_pattern;
        else if (host_addr == APR_ADDR_SUMMARY) next_rdata = summary;
        else if (host_addr == APR_ADDR_RX_CFG) next_rdata = rx_shared_config;
      end
    endcase
  end

  // shared registers and read data
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filler <= APR_RST_FILLER;
      hec_error_pattern <= APR_RST_HEC_PAT;
      rx_shared_config <= APR_RST_RX_CFG;
      tx_cell_count <= 16'h0000;
      host_rdata <= 8'h00;
    end else begin
      if (host_rd) host_rdata <= next_rdata;
      if (wr_latch) tx_cell_count <= cnt.count[port_sel*16 +: 16];
      if (host_wr && host_addr == APR_ADDR_FILLER) filler <= host_wdata;
      if (host_wr && host_addr == APR_ADDR_HEC_PAT) hec_error_pattern <= host_wdata;
      if (host_wr && host_addr == APR_ADDR_RX_CFG)
        rx_shared_config <= {APR_RST_RX_CFG[7:4], host_wdata[3:0]};
    end
  end

  // external status synchroniser, three stages
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_s1 <= 8'h00;
      ext_s2 <= 8'h00;
      ext_s3 <= 8'h00;
      ext_lvl <= 8'h00;
      lost_q <= 8'hff;
    end else begin
      ext_s1 <= ext_status;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      ext_lvl <= (ext_s2 & ext_s3) | (ext_lvl & (ext_s2 | ext_s3)); // follows only agreed levels
      lost_q <= lost_now;
    end
  end

  // per-port control, events, hec pattern and rx fifo fill
  always_ff @(posedge ref_clk or negedge nrst) begin
    for (int i = 0; i < APR_PORTS; i++) begin
      if (!nrst) begin
        tx_line_ctrl[i] <= 8'h00;
        tx_cell_ctrl[i] <= APR_RST_TX_CELL;
        rx_cell_control[i] <= 8'h00;
        rx_line_irq_control[i] <= 8'h00;
        evt[i] <= 8'h00;
        fill[i] <= 3'h0;
        hec_run[i] <= 5'h00;
        hec_bad_phase[i] <= 1'b0;
      end else begin
        if (host_wr && port_sel == 3'(i)) begin
          if (off == APR_OFF_TX_LINE_CTRL) tx_line_ctrl[i] <= host_wdata;
          if (off == APR_OFF_TX_CELL_CTRL) tx_cell_ctrl[i] <= host_wdata;
          if (off == APR_OFF_RX_CELL) rx_cell_control[i] <= host_wdata;
          if (off == APR_OFF_RX_IRQ) rx_line_irq_control[i] <= host_wdata;
        end
        // read clears, then any event of this cycle sets again
        if (rd_status && port_sel == 3'(i)) evt[i] <= 8'h00;
        if (rx_cell_stored[i] && fill[i] == APR_FIFO_CAP) evt[i][APR_ST_OVR] <= 1'b1;
        if (lost_now[i] != lost_q[i]) evt[i][APR_ST_DCHG] <= 1'b1;
        if (tx_parity_err[i]) evt[i][APR_ST_PAR] <= 1'b1;
        if (ext_rise[i]) evt[i][APR_ST_EXT] <= 1'b1;
        // full fifo keeps its cells and drops new ones
        if (rx_cell_stored[i] && fill[i] != APR_FIFO_CAP && !rx_cell_read[i])
          fill[i] <= fill[i] + 3'h1;
        else if (rx_cell_read[i] && fill[i] != 3'h0 &&
                 !(rx_cell_stored[i] && fill[i] != APR_FIFO_CAP))
          fill[i] <= fill[i] - 3'h1;
        // off period good, on period bad, repeat while enabled
        if (!tx_cell_ctrl[i][APR_TX_HEC_ERR]) begin
          hec_run[i] <= 5'h00;
          hec_bad_phase[i] <= 1'b0;
        end else if (tx_hec_cell[i]) begin
          if (!hec_bad_phase[i] && hec_run[i] + 5'h01 >= hec_error_pattern[7:3]) begin
            hec_run[i] <= 5'h00;
            hec_bad_phase[i] <= hec_error_pattern[2:0] != 3'h0;
          end else if (hec_bad_phase[i] && hec_run[i] + 5'h01 >= {2'b00, hec_error_pattern[2:0]}) begin
            hec_run[i] <= 5'h00;
            hec_bad_phase[i] <= hec_error_pattern[7:3] == 5'h00;
          end else begin
            hec_run[i] <= hec_run[i] + 5'h01;
          end
        end
      end
    end
  end

  // summary and interrupt
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      summary <= 8'h00;
      irq_n <= 1'b1;
    end else begin
      for (int i = 0; i < APR_PORTS; i++) begin
        summary[i] <= pend(i);
      end
      irq_n <= !(pend(0) || pend(1) || pend(2) || pend(3) ||
                 pend(4) || pend(5) || pend(6) || pend(7));
    end
  end

  // system clock divided by 8 for the line side
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 3'h0;
      div_clk <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
      if (div_cnt == APR_CLK_DIV) div_clk <= 1'b0;
      if (div_cnt == 3'h3) div_clk <= 1'b1;
    end
  end

  // receive cell decisions for the port now presenting a header
  assign rx_state = apr_delin_t'(delin_state[rx_port*2 +: 2]);
  assign rx_sync = rx_state[1];
  assign hec_chk = rx_cell_control[rx_port][APR_RX_COSET] ?
                   rx_hec_byte - APR_COSET : rx_hec_byte;
  assign rx_hec_good = hec_chk == rx_hec_calc;

  // registered outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_line_clock <= 8'h00;
      tx_fifo_depth <= {8{APR_FIFO_CAP}};
      filler_payload_byte <= APR_RST_FILLER;
      tx_bad_hec <= 8'h00;
      rx_line_type <= 8'h00;
      rx_poll_cfg <= 8'h00;
      rx_null_port <= 8'h00;
      rx_hec_ok <= 1'b0;
      rx_correct <= 1'b0;
      rx_descramble <= 1'b0;
      rx_forward <= 1'b0;
      rx_fifo_full <= 8'h00;
      rx_sel_data <= 8'h00;
      rx_sel_clock <= 8'h00;
    end else begin
      filler_payload_byte <= filler;
      rx_hec_ok <= rx_hec_good;
      rx_correct <= rx_cell_control[rx_port][APR_RX_CORR] && !rx_error_mode[rx_port] &&
                    rx_hec_single;
      rx_descramble <= rx_cell_control[rx_port][APR_RX_DESCR] && rx_state != APR_HUNT;
      rx_forward <= rx_sync &&
                    (rx_hec_good || (rx_cell_control[rx_port][APR_RX_CORR] &&
                     !rx_error_mode[rx_port] && rx_hec_single) ||
                     rx_cell_control[rx_port][APR_RX_PASS]) &&
                    !(rx_hec_good && rx_cell_control[rx_port][APR_RX_IDLE] &&
                      rx_header == 32'h00000001) &&
                    !(rx_hec_good && rx_cell_control[rx_port][APR_RX_UNAS] &&
                      rx_header == 32'h00000000);
      for (int i = 0; i < APR_PORTS; i++) begin
        tx_line_clock[i] <= tx_line_ctrl[i][APR_TX_CLK_SEL] ? div_clk : framer_tx_clock[i];
        tx_fifo_depth[i*3 +: 3] <= depth_cells(tx_line_ctrl[i][5:4]);
        tx_bad_hec[i] <= tx_cell_ctrl[i][APR_TX_HEC_ERR] && hec_bad_phase[i];
        rx_line_type[i] <= rx_shared_config[0];
        rx_poll_cfg[i] <= rx_shared_config[1];
        rx_fifo_full[i] <= fill[i] == APR_FIFO_CAP;
        rx_sel_data[i] <= rx_line_irq_control[i][APR_RX_LOOP] ? tx_data[i] : rx_line_data[i];
        rx_sel_clock[i] <= rx_line_irq_control[i][APR_RX_LOOP] ?
                           tx_line_clock[i] : rx_line_clock[i];
      end
      rx_null_port <= rx_shared_config[3:2] == 2'b11 ? 8'h80 : 8'h00;
    end
  end

  // interrupt follows enabled flags one cycle later
  irq_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (evt[0][APR_ST_PAR] && tx_cell_ctrl[0][APR_TX_PAR_MASK]) |=> !irq_n)
    else $error("interrupt missing for enabled flag");
  // latch copies count, later reads keep it
  latch_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !wr_latch |=> tx_cell_count == $past(tx_cell_count))
    else $error("latched count changed without latch write");
  // filler output tracks register
  filler_out_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> filler_payload_byte == $past(filler))
    else $error("filler byte output wrong");
  // set beats read clear
  set_wins_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tx_parity_err[1] && rd_status && port_sel == 3'h1) |=> evt[1][APR_ST_PAR])
    else $error("parity event lost at read clear");
  // summary stays clear while port 2 has no flags
  summary_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (evt[2] == 8'h00) |=> !summary[2])
    else $error("summary set with no flag");
  // full fifo holds at four
  fifo_cap_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    fill[0] <= APR_FIFO_CAP)
    else $error("rx fifo fill beyond capacity");
  // overrun flag set on store into full fifo
  overrun_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rx_cell_stored[0] && fill[0] == APR_FIFO_CAP) |=> evt[0][APR_ST_OVR])
    else $error("overrun not flagged");
  // depth encoding
  depth_map_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_line_ctrl[2][5:4] == 2'b10 |=> tx_fifo_depth[8:6] == 3'h2)
    else $error("fifo depth encoding wrong");
endmodule

// [dv/apr_host_model.sv]
/*
  host processor model on the 8-bit register port: single writes and reads.
  assumes host_rdata is valid the edge after the read strobe is taken.
*/
`timescale 1ns/1ps
module apr_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] host_rdata,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd
);
  // idle bus at time zero
  initial begin
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end

  // one-cycle write pulse; data line shows the inverse once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask

  // latch request always carries 00; the register rows read count register 0x22 before the first latch
  task automatic latch(input logic [2:0] port);
    wr({port, 5'h01}, 8'h00);
  endtask

  // one-cycle read pulse, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    #1 v = host_rdata;
  endtask
endmodule

// [dv/apr_port_regs_bench.sv]
/*
  self-checking bench for the port register bank: table of register rows, then
  counters, fifo depth, status flags, summary and receive controls.
  assumes the host model drives the register port and the bench the datapath side.
*/
`timescale 1ns/1ps
module apr_port_regs_bench;
  import apr_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] host_addr, host_wdata, host_rdata, v;
  logic host_wr, host_rd, irq_n;
  logic [7:0] tx_cell_sent = 8'h00, tx_parity_err = 8'h00, ext_status = 8'h00;
  logic [7:0] rx_cell_stored = 8'h00, rx_cell_read = 8'h00, rx_error_mode = 8'h00;
  logic [15:0] delin_state = 16'h0000;
  logic [7:0] rx_hec_byte = 8'h00, rx_hec_calc = 8'h00;
  logic [7:0] tx_hec_cell = 8'h00, framer_tx_clock = 8'h00, tx_data = 8'h00;
  logic [31:0] rx_header = 32'h00000000;
  logic rx_hec_single = 1'b0;
  logic [7:0] tx_line_clock, tx_bad_hec, rx_line_type, rx_poll_cfg, rx_sel_data, rx_sel_clock;
  logic rx_correct, rx_forward;
  int n = 0;
  logic [2:0] rx_port = 3'h0;
  logic [23:0] tx_fifo_depth;
  logic [7:0] filler_payload_byte, rx_null_port, rx_fifo_full;
  logic rx_hec_ok, rx_descramble;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  // rows: address, write data, expected read back
  logic [23:0] rows [6] = '{24'h04a5a5, 24'h053b3b, 24'h392c2c, 24'h100f1f, 24'h22ff00,
    24'h097700};

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  apr_host_model host (.ref_clk(ref_clk), .host_rdata(host_rdata), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd));

  apr_port_regs uut (.ref_clk(ref_clk), .nrst(nrst), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .irq_n(irq_n), .tx_cell_sent(tx_cell_sent), .tx_parity_err(tx_parity_err),
    .ext_status(ext_status), .rx_cell_stored(rx_cell_stored), .rx_cell_read(rx_cell_read),
    .delin_state(delin_state), .rx_error_mode(rx_error_mode),
    .framer_tx_clock(framer_tx_clock), .tx_hec_cell(tx_hec_cell), .rx_hec_byte(rx_hec_byte),
    .rx_hec_calc(rx_hec_calc), .rx_header(rx_header), .rx_hec_single(rx_hec_single),
    .rx_port(rx_port), .tx_data(tx_data), .rx_line_data(8'h00), .rx_line_clock(8'h00),
    .tx_line_clock(tx_line_clock), .tx_fifo_depth(tx_fifo_depth),
    .filler_payload_byte(filler_payload_byte), .tx_bad_hec(tx_bad_hec),
    .rx_line_type(rx_line_type), .rx_poll_cfg(rx_poll_cfg), .rx_null_port(rx_null_port),
    .rx_hec_ok(rx_hec_ok), .rx_correct(rx_correct), .rx_descramble(rx_descramble),
    .rx_forward(rx_forward), .rx_fifo_full(rx_fifo_full), .rx_sel_data(rx_sel_data),
    .rx_sel_clock(rx_sel_clock));

  // counted comparison with one line per mismatch
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read one register and compare it
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk($sformatf("reg %h", a), {16'h0, exp}, {16'h0, v});
  endtask

  // cnt single-cycle pulses on one port: cells sent, or hec-carrying cells
  task automatic cells(input bit hec, input int port, input int cnt);
    repeat (cnt) begin
      @(posedge ref_clk);
      if (hec) tx_hec_cell <= 8'h01 << port;
      else tx_cell_sent <= 8'h01 << port;
      @(posedge ref_clk);
      tx_hec_cell <= 8'h00;
      tx_cell_sent <= 8'h00;
    end
  endtask

  task automatic close_out;
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("filler out", 24'h6a, {16'h0, filler_payload_byte});
    chk("fifo depth", {8{3'h4}}, tx_fifo_depth);
    chk("irq idle", 24'h1, {23'h0, irq_n});
    rchk(8'h04, 8'h6a);
    // plain register rows
    foreach (rows[i]) begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0]);
    end
    chk("null port", 24'h80, {16'h0, rx_null_port});
    chk("line type", 24'hff, {16'h0, rx_line_type});
    chk("poll mode", 24'hff, {16'h0, rx_poll_cfg});
    // latched transmit count, aliases, no relatch, clear after latch
    cells(1'b0, 1, 5);
    host.latch(3'h1);
    rchk(8'h42, 8'h00);
    rchk(8'h63, 8'h05);
    rchk(8'he3, 8'h05);
    cells(1'b0, 1, 2);
    rchk(8'h03, 8'h05);
    host.latch(3'h1);
    rchk(8'h03, 8'h02);
    // fifo depth codes on port 2
    for (int c = 0; c < 3; c++) begin
      host.wr(8'h47, {2'b00, c[1:0], 4'h0});
      repeat (2) @(posedge ref_clk);
      chk("depth p2", {21'h0, 3'(4 - c)}, {21'h0, tx_fifo_depth[8:6]});
    end
    // masked overrun on port 0 reaches irq and summary, read clears
    host.wr(8'h1a, 8'h08);
    repeat (5) begin
      @(posedge ref_clk) rx_cell_stored <= 8'h01;
      @(posedge ref_clk) rx_cell_stored <= 8'h00;
    end
    repeat (3) @(posedge ref_clk);
    chk("fifo full", 24'h1, {23'h0, rx_fifo_full[0]});
    chk("irq set", 24'h0, {23'h0, irq_n});
    @(posedge ref_clk) rx_cell_read <= 8'h01;
    @(posedge ref_clk) rx_cell_read <= 8'h00;
    repeat (2) @(posedge ref_clk);
    chk("fifo drained", 24'h0, {23'h0, rx_fifo_full[0]});
    rchk(8'h08, 8'h01);
    rchk(8'h18, 8'h05);
    rchk(8'h18, 8'h04);
    repeat (3) @(posedge ref_clk);
    chk("irq clear", 24'h1, {23'h0, irq_n});
    rchk(8'h08, 8'h00);
    // unmasked external edge on port 3 flags but stays out of summary
    @(posedge ref_clk) ext_status <= 8'h08;
    repeat (6) @(posedge ref_clk);
    rchk(8'h08, 8'h00);
    rchk(8'h78, 8'h84);
    rchk(8'h78, 8'h04);
    // delineation reaches sync on port 0
    @(posedge ref_clk) delin_state <= 16'h0002;
    repeat (4) @(posedge ref_clk);
    rchk(8'h18, 8'h22);
    rchk(8'h18, 8'h20);
    // coset removal and descrambling for port 0 in sync
    host.wr(8'h19, 8'h05);
    @(posedge ref_clk) rx_hec_calc <= 8'h12;
    rx_hec_byte <= 8'h67;
    repeat (3) @(posedge ref_clk);
    chk("hec ok", 24'h1, {23'h0, rx_hec_ok});
    chk("descramble", 24'h1, {23'h0, rx_descramble});
    chk("forward", 24'h1, {23'h0, rx_forward});
    // unassigned filter drops header zero, keeps the idle header
    host.wr(8'h19, 8'h25);
    repeat (2) @(posedge ref_clk);
    chk("unassigned drop", 24'h0, {23'h0, rx_forward});
    rx_header <= 32'h00000001;
    repeat (2) @(posedge ref_clk);
    chk("idle kept", 24'h1, {23'h0, rx_forward});
    // single-bit error corrected and passed in correction mode
    host.wr(8'h19, 8'h03);
    rx_hec_single <= 1'b1;
    rx_hec_calc <= 8'h13;
    repeat (2) @(posedge ref_clk);
    chk("correct", 24'h1, {23'h0, rx_correct});
    chk("corrected pass", 24'h1, {23'h0, rx_forward});
    // framer clock, loopback of data and clock, then divided clock
    framer_tx_clock <= 8'hff;
    tx_data <= 8'h01;
    host.wr(8'h1a, 8'h09);
    repeat (3) @(posedge ref_clk);
    chk("framer clock", 24'h1, {23'h0, tx_line_clock[0]});
    chk("loop data", 24'h1, {23'h0, rx_sel_data[0]});
    chk("loop clock", 24'h1, {23'h0, rx_sel_clock[0]});
    host.wr(8'h07, 8'h40);
    @(posedge ref_clk);
    n = 0;
    repeat (8) @(negedge ref_clk) n += tx_line_clock[0];
    chk("divided clock", 24'd4, n[23:0]);
    // error pattern 0x3b: seven good cells, three bad, repeat
    host.wr(8'h06, 8'h47);
    cells(1'b1, 0, 6);
    repeat (2) @(posedge ref_clk);
    chk("hec good run", 24'h0, {23'h0, tx_bad_hec[0]});
    cells(1'b1, 0, 1);
    repeat (2) @(posedge ref_clk);
    chk("hec bad run", 24'h1, {23'h0, tx_bad_hec[0]});
    cells(1'b1, 0, 3);
    repeat (2) @(posedge ref_clk);
    chk("hec repeat", 24'h0, {23'h0, tx_bad_hec[0]});
    // masked tx parity error on port 0 interrupts
    @(posedge ref_clk) tx_parity_err <= 8'h01;
    @(posedge ref_clk) tx_parity_err <= 8'h00;
    repeat (2) @(posedge ref_clk);
    chk("parity irq", 24'h0, {23'h0, irq_n});
    rchk(8'h18, 8'h60);
    // parity event in the same cycle as the clearing read survives
    fork
      host.rd(8'h38, v);
      begin
        @(posedge ref_clk) tx_parity_err <= 8'h02;
        @(posedge ref_clk) tx_parity_err <= 8'h00;
      end
    join
    chk("race read", 24'h04, {16'h0, v});
    rchk(8'h38, 8'h44);
    // reset in mid-run restores the defaults
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("irq after reset", 24'h1, {23'h0, irq_n});
    rchk(8'h05, 8'h00);
    rchk(8'h10, 8'h10);
    rchk(8'h04, 8'h6a);
    close_out();
  end
endmodule
